// >>> hdl/mmbp_host.sv
// module: host that bit-bangs management frames onto the phy clock and data lines
`timescale 1ns/1ps
// How it works
// - read cycle: clock low, wait, clock high, wait, sample, wait
// - write cycle: clock low, wait, clock high with data, wait
// - z cycle: clock low, wait, clock high, release direction, wait
// - every wait lasts at least 200 ns, counted in clock cycles
// - frame opens with direction set and 32 ones of preamble
// - start of frame sends two bits of value one
// - read frame opcode is two
// - write frame opcode is one
// - five phy address bits then five register address bits
// - read turnaround is z then read; sampled one means no phy
// - sixteen read bits arrive msb first
// - write turnaround sends two bits of value two
// - sixteen write bits go out msb first
// - every frame ends with one z cycle, line released
module mmbp_host
  import mmbp_pkg::*;
#(
  parameter int PHASE_CYC = mmbp_pkg::MIN_PHASE_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        start_in,
  input  wire logic        is_write_in,
  input  wire logic [4:0]  phy_addr_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        mdio_in,
  output logic             mdc_out,
  output logic             mdio_out,
  output logic             mdio_oe_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             no_phy_out,
  output logic [15:0]      rdata_out
);
  import mmbp_pkg::*;

  logic              mdio_s1_r;
  logic              mdio_s2_r;
  mmbp_phase_e       phase_r;
  mmbp_field_e       field_r;
  logic [PH_W-1:0]   wait_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              wr_r;
  logic [13:0]       hdr_r;
  logic [15:0]       wsh_r;
  logic              tx_bit;
  logic              is_read_cyc;
  logic              is_z_cyc;
  logic              last_bit;
  logic              wait_done;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser for the phy data line
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mdio_s1_r <= 1'b0;
      mdio_s2_r <= 1'b0;
    end else begin
      mdio_s1_r <= mdio_in;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // what the current bit cycle is and which bit it carries
  always_comb begin
    is_read_cyc = (field_r == MMBP_RTA) || (field_r == MMBP_DATA && !wr_r);
    is_z_cyc    = (field_r == MMBP_RZ) || (field_r == MMBP_ENDZ);
    unique case (field_r)
      MMBP_PRE:  tx_bit = 1'b1;
      MMBP_HDR:  tx_bit = hdr_r[13];
      MMBP_WTA:  tx_bit = (cnt_r == '0) ? TA_WRITE[1] : TA_WRITE[0];
      MMBP_DATA: tx_bit = wsh_r[15];
      default:   tx_bit = 1'b0;
    endcase
    unique case (field_r)
      MMBP_PRE:  last_bit = (cnt_r == CNT_W'(PREAMBLE_BITS - 1));
      MMBP_HDR:  last_bit = (cnt_r == CNT_W'(HDR_BITS - 1));
      MMBP_WTA:  last_bit = (cnt_r == CNT_W'(1));
      MMBP_DATA: last_bit = (cnt_r == CNT_W'(DATA_BITS - 1));
      default:   last_bit = 1'b1;
    endcase
    wait_done = (wait_r == '0);
  end

  ////////////////////////////////////////////////////////////////////////
  // bit cycle phases; each wait is a full 200 ns count
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      phase_r <= MMBP_IDLE;
      wait_r  <= '0;
    end else begin
      unique case (phase_r)
        MMBP_IDLE: if (start_in) begin
          phase_r <= MMBP_LOW;
          wait_r  <= PH_W'(PHASE_CYC - 1);
        end
        MMBP_LOW: if (wait_done) begin
          phase_r <= MMBP_HIGH;
          wait_r  <= PH_W'(PHASE_CYC - 1);
        end else wait_r <= wait_r - 1'b1;
        MMBP_HIGH: if (wait_done) begin
          phase_r <= is_read_cyc ? MMBP_SAMPLE : (
                     (field_r == MMBP_ENDZ) ? MMBP_DONE : MMBP_LOW);
          wait_r  <= PH_W'(PHASE_CYC - 1);
        end else wait_r <= wait_r - 1'b1;
        MMBP_SAMPLE: if (wait_done) begin        // trailing wait
          phase_r <= MMBP_LOW;
          wait_r  <= PH_W'(PHASE_CYC - 1);
        end else wait_r <= wait_r - 1'b1;
        MMBP_DONE: phase_r <= MMBP_IDLE;
        default:   phase_r <= MMBP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame field sequencing, advanced at the end of each bit cycle
  logic bit_end;
  assign bit_end = wait_done && ((phase_r == MMBP_SAMPLE) ||
                   (phase_r == MMBP_HIGH && !is_read_cyc));
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      field_r <= MMBP_PRE;
      cnt_r   <= '0;
      wr_r    <= 1'b0;
      hdr_r   <= '0;
      wsh_r   <= '0;
    end else if (phase_r == MMBP_IDLE && start_in) begin
      field_r <= MMBP_PRE;
      cnt_r   <= '0;
      wr_r    <= is_write_in;
      hdr_r   <= {SOF_CODE, (is_write_in ? OP_WRITE : OP_READ),
                  phy_addr_in, reg_addr_in};
      wsh_r   <= wdata_in;
    end else if (bit_end) begin
      if (field_r == MMBP_HDR) hdr_r <= {hdr_r[12:0], 1'b0};
      if (field_r == MMBP_DATA && wr_r) wsh_r <= {wsh_r[14:0], 1'b0};
      cnt_r <= last_bit ? '0 : cnt_r + 1'b1;
      if (last_bit) begin
        unique case (field_r)
          MMBP_PRE:  field_r <= MMBP_HDR;
          MMBP_HDR:  field_r <= wr_r ? MMBP_WTA : MMBP_RZ;
          MMBP_WTA:  field_r <= MMBP_DATA;
          MMBP_RZ:   field_r <= MMBP_RTA;
          MMBP_RTA:  field_r <= MMBP_DATA;
          MMBP_DATA: field_r <= MMBP_ENDZ;
          MMBP_ENDZ: field_r <= MMBP_ENDZ;
          default:   field_r <= MMBP_PRE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive: clock bit, data bit and direction bit as registers
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      mdc_out     <= 1'b0;
      mdio_out    <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else begin
      if (phase_r == MMBP_IDLE && start_in) begin
        mdc_out     <= 1'b0;
        mdio_oe_out <= 1'b1;
      end else if (phase_r == MMBP_LOW && wait_done) begin
        mdc_out <= 1'b1;
        if (is_z_cyc) mdio_oe_out <= 1'b0;
        else if (!is_read_cyc) mdio_out <= tx_bit;
      end else if (bit_end && !(field_r == MMBP_ENDZ)) begin
        mdc_out <= 1'b0;                          // next cycle opens clock low
      end else if (phase_r == MMBP_DONE) begin
        mdc_out     <= 1'b0;
        mdio_oe_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read capture; sampled after the high wait, msb first
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      rdata_out  <= '0;
      no_phy_out <= 1'b0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      done_out <= (phase_r == MMBP_DONE);
      busy_out <= (phase_r != MMBP_IDLE && phase_r != MMBP_DONE) ||
                  (phase_r == MMBP_IDLE && start_in);
      if (phase_r == MMBP_IDLE && start_in) no_phy_out <= 1'b0;
      if (phase_r == MMBP_HIGH && wait_done && field_r == MMBP_RTA)
        no_phy_out <= mdio_s2_r;
      if (phase_r == MMBP_HIGH && wait_done && field_r == MMBP_DATA && !wr_r)
        rdata_out <= {rdata_out[14:0], mdio_s2_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_release_on_z;
    @(posedge clock_in) disable iff (!reset_n_in)
    (phase_r == MMBP_LOW && wait_done && is_z_cyc) |=> !mdio_oe_out;
  endproperty
  a_release_on_z: assert property (p_release_on_z) else $error("line not released");
  property p_clock_high;
    @(posedge clock_in) disable iff (!reset_n_in)
    $rose(mdc_out) |-> mdc_out [*8];
  endproperty
  a_clock_high: assert property (p_clock_high) else $error("clock high too short");
  property p_clock_low;
    @(posedge clock_in) disable iff (!reset_n_in)
    ($fell(mdc_out) && busy_out) |-> !mdc_out [*8];
  endproperty
  a_clock_low: assert property (p_clock_low) else $error("clock low too short");
  property p_drive_start;
    @(posedge clock_in) disable iff (!reset_n_in)
    (phase_r == MMBP_IDLE && start_in) |=> mdio_oe_out && !mdc_out;
  endproperty
  a_drive_start: assert property (p_drive_start) else $error("frame not driven");
  property p_preamble_ones;
    @(posedge clock_in) disable iff (!reset_n_in)
    (field_r == MMBP_PRE && $rose(mdc_out)) |-> mdio_out;
  endproperty
  a_preamble_ones: assert property (p_preamble_ones) else $error("preamble bit zero");
  property p_stable_data;
    @(posedge clock_in) disable iff (!reset_n_in)
    (mdc_out && mdio_oe_out) |=> $stable(mdio_out) || $rose(mdc_out);
  endproperty
  a_stable_data: assert property (p_stable_data) else $error("data moved while clock high");
  property p_end_release;
    @(posedge clock_in) disable iff (!reset_n_in)
    done_out |-> !mdio_oe_out && !mdc_out;
  endproperty
  a_end_release: assert property (p_end_release) else $error("frame end not released");
  property p_read_released;
    @(posedge clock_in) disable iff (!reset_n_in)
    (is_read_cyc && mdc_out) |-> !mdio_oe_out;
  endproperty
  a_read_released: assert property (p_read_released) else $error("driving during read");
  c_write: cover property (@(posedge clock_in) done_out && wr_r);
  c_read:  cover property (@(posedge clock_in) done_out && !wr_r && !no_phy_out);
  c_nophy: cover property (@(posedge clock_in) done_out && no_phy_out);
endmodule

// >>> hdl/mmbp_pkg.sv
// package: constants for the management frame sequencer (host side of the serial port)
package mmbp_pkg;
  localparam int  CLK_PERIOD_NS   = 20;
  localparam int  MIN_PHASE_NS    = 200;
  // least time rounds up to whole clock cycles
  localparam int  MIN_PHASE_CYC   = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  PREAMBLE_BITS   = 32;
  localparam int  HDR_BITS        = 14;     // start, opcode, phy and register address
  localparam int  DATA_BITS       = 16;
  localparam logic [1:0] SOF_CODE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam int  CNT_W           = 6;
  localparam int  PH_W            = 8;
  typedef enum logic [2:0] {
    MMBP_IDLE, MMBP_LOW, MMBP_HIGH, MMBP_SAMPLE, MMBP_DONE
  } mmbp_phase_e;
  typedef enum logic [2:0] {
    MMBP_PRE, MMBP_HDR, MMBP_WTA, MMBP_RZ, MMBP_RTA, MMBP_DATA, MMBP_ENDZ
  } mmbp_field_e;
endpackage

// >>> tb/mmbp_host_tb.sv
// file: self-checking bench for the management frame host
`timescale 1ns/1ps
module mmbp_host_tb;
  import mmbp_pkg::*;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        start_in = 1'b0;
  logic        is_write_in = 1'b0;
  logic        present = 1'b1;
  logic [4:0]  phy_addr = '0;
  logic [4:0]  reg_addr = '0;
  logic [15:0] wdata = '0;
  logic [15:0] reg_value = 16'h8E71;
  logic        mdc, mdio_out, mdio_oe, busy, done, no_phy, mdio_line;
  logic [15:0] rdata;
  logic [63:0] seen;
  int          n_seen;
  realtime     min_phase;
  int          n_fail = 0;
  int          compares = 0;
  mmbp_host mmbp_host_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .start_in(start_in),
    .is_write_in(is_write_in), .phy_addr_in(phy_addr), .reg_addr_in(reg_addr),
    .wdata_in(wdata), .mdio_in(mdio_line), .mdc_out(mdc), .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe), .busy_out(busy), .done_out(done), .no_phy_out(no_phy),
    .rdata_out(rdata));
  mmbp_phy_model mmbp_phy_model_i (.mdc_in(mdc), .mdio_out_in(mdio_out), .mdio_oe_in(mdio_oe),
    .present_in(present), .reg_value_in(reg_value), .mdio_line_out(mdio_line),
    .seen_out(seen), .n_seen_out(n_seen), .min_phase_out(min_phase));
  initial forever #10 clock_in = ~clock_in;
  task automatic end_of_test;
    $display("tests done: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check_vec(input logic [63:0] exp, input logic [63:0] got, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one frame; poke re-requests mid-frame, which must be ignored
  task automatic run_frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
                           input logic [15:0] wd, input logic poke);
    int n;
    @(negedge clock_in);
    {is_write_in, phy_addr, reg_addr, wdata, start_in} = {wr, pa, ra, wd, 1'b1};
    @(negedge clock_in);
    start_in = 1'b0;
    check_vec(1, busy, "busy in frame");
    for (n = 0; n < 4000 && done !== 1'b1; n++) begin
      @(negedge clock_in);
      start_in = poke && n == 100;
    end
    check_vec(1, done, "done");
    @(negedge clock_in);
    check_vec(0, done, "done pulse ends");
    repeat (2) @(negedge clock_in);
    check_vec(0, {busy, mdio_oe, mdc}, "idle after frame");
    check_vec(1, min_phase >= 200.0, "phase length");
  endtask
  task automatic test_write;
    run_frame(1'b1, 5'h15, 5'h0A, 16'hA5C3, 1'b0);
    check_vec(64, n_seen, "write bit count");
    check_vec({32'hFFFFFFFF, SOF_CODE, OP_WRITE, 5'h15, 5'h0A, TA_WRITE, 16'hA5C3},
              seen, "write frame bits");
    $display("test write done");
  endtask
  task automatic test_read(input logic here, input logic poke);
    present = here;
    run_frame(1'b0, 5'h01, 5'h1F, 16'h0000, poke);
    check_vec(46, n_seen, "read header count");
    check_vec({18'h0, 32'hFFFFFFFF, SOF_CODE, OP_READ, 5'h01, 5'h1F},
              seen, "read header bits");
    check_vec(!here, no_phy, "no phy flag");
    if (here) check_vec(reg_value, rdata, "read data");
    $display("test read done");
  endtask
  // reset in mid-frame must abandon the frame and leave the pins idle
  task automatic test_reset_mid;
    @(negedge clock_in);
    is_write_in = 1'b1;
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    // lands in a clock-low phase, so no short clock phase is made
    repeat (300) @(negedge clock_in);
    check_vec(1, busy, "busy before reset");
    reset_n_in = 1'b0;
    repeat (3) @(negedge clock_in);
    check_vec(0, {mdc, mdio_oe, busy, done}, "outputs in reset");
    reset_n_in = 1'b1;
    $display("test reset mid done");
  endtask
  initial begin
    repeat (3) @(negedge clock_in);
    reset_n_in = 1'b1;
    check_vec(0, {mdc, mdio_oe, busy, done}, "reset outputs");
    $display("test reset done");
    test_write();
    test_reset_mid();
    test_read(1'b1, 1'b1);
    test_read(1'b0, 1'b0);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    $display("mismatch at %0t: watchdog ran out", $time);
    end_of_test();
  end
endmodule

// >>> tb/mmbp_phy_model.sv
// file: behavioural phy answering management frames on the serial lines
`timescale 1ns/1ps
module mmbp_phy_model (
  input  wire logic        mdc_in,
  input  wire logic        mdio_out_in,
  input  wire logic        mdio_oe_in,
  input  wire logic        present_in,
  input  wire logic [15:0] reg_value_in,
  output logic             mdio_line_out,
  output logic [63:0]      seen_out,
  output int               n_seen_out,
  output realtime          min_phase_out
);
  logic    drive_r = 1'b0;
  logic    bit_r   = 1'b1;
  int      idx_r   = 0;
  realtime last_r  = 0.0;
  initial min_phase_out = 1.0e9;
  // pulled up when nobody drives, so an absent phy reads as one
  assign mdio_line_out = mdio_oe_in ? mdio_out_in : (drive_r ? bit_r : 1'b1);
  // a frame opens when the host takes the line
  always @(posedge mdio_oe_in) begin
    n_seen_out = 0;
    seen_out   = '0;
    idx_r      = 0;
  end
  // host data is settled a little after the rising clock
  always @(posedge mdc_in) begin
    #5;
    if (mdio_oe_in) begin
      seen_out = {seen_out[62:0], mdio_out_in};
      n_seen_out++;
    end
  end
  // answer only a read header: 46 written bits, then turnaround zero and msb first data
  always @(negedge mdc_in) begin
    if (!mdio_oe_in && n_seen_out == 46 && idx_r < 17 && present_in) begin
      drive_r = 1'b1;
      bit_r   = (idx_r == 0) ? 1'b0 : reg_value_in[16-idx_r];
      idx_r++;
    end else begin
      drive_r = 1'b0;
    end
  end
  // shortest clock phase seen, after the reset settles
  always @(mdc_in) begin
    if ($realtime > 100.0 && $realtime - last_r < min_phase_out) begin
      min_phase_out = $realtime - last_r;
    end
    last_r = $realtime;
  end
endmodule
